// ### pkg/exec_regs.svh
// constants for the rotate / sleep / subtract-with-borrow executer
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define EXEC_OP_ROTATE 2'h1
`define EXEC_OP_SLEEP 2'h2
`define EXEC_OP_SUBB 2'h3
`define EXEC_ACCESS_BOUND 8'h5F
`define EXEC_ACCESS_SPLIT 8'h60
`define EXEC_ACC_RESET 8'h00
`define EXEC_WDT_RESET 8'h00
`define EXEC_PS_RESET 8'h00
`define EXEC_ST_N 4
`define EXEC_ST_OV 3
`define EXEC_ST_Z 2
`define EXEC_ST_DC 1
`define EXEC_ST_C 0
`endif

// ### pkg/exec_pkg.sv
// types for the rotate / sleep / subtract-with-borrow executer
package exec_pkg;
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_e;
    typedef enum logic [0:0] {
        RUN_ACTIVE = 1'b0,
        RUN_ASLEEP = 1'b1
    } run_e;
endpackage : exec_pkg

// ### verilog/exec_alu.sv
// operand address mapping and arithmetic for one instruction
`include "exec_regs.svh"
module exec_alu (
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_f_addr,
    input wire logic i_access_sel,
    input wire logic i_ext_en,
    input wire logic [3:0] i_bank_sel,
    input wire logic [11:0] i_fsr2,
    input wire logic [7:0] i_src,
    input wire logic [7:0] i_acc,
    input wire logic i_carry,
    output logic [11:0] o_addr,
    output logic [7:0] o_result,
    output logic [4:0] o_status_flags,
    output logic o_flags_valid
);
    logic [8:0] diff;
    logic [4:0] low_diff;
    always_comb begin
        if (!i_access_sel && i_ext_en && i_f_addr <= `EXEC_ACCESS_BOUND) begin
            o_addr = i_fsr2 + {4'h0, i_f_addr};
        end else if (!i_access_sel) begin
            // access bank: low part of bank 0 or top of bank F
            o_addr = (i_f_addr < `EXEC_ACCESS_SPLIT) ? {4'h0, i_f_addr} : {4'hF, i_f_addr};
        end else begin
            o_addr = {i_bank_sel, i_f_addr};
        end
        // borrow is the inverted carry, so add carry and the complement
        diff = {1'b0, i_acc} + {1'b0, ~i_src} + {8'h00, i_carry};
        low_diff = {1'b0, i_acc[3:0]} + {1'b0, ~i_src[3:0]} + {4'h0, i_carry};
        o_result = 8'h00;
        o_status_flags = 5'h00;
        o_flags_valid = 1'b0;
        unique case (i_op)
            `EXEC_OP_ROTATE: begin
                o_result = {i_src[0], i_src[7:1]};
                o_status_flags[`EXEC_ST_N] = i_src[0];
                o_status_flags[`EXEC_ST_Z] = (i_src == 8'h00);
            end
            `EXEC_OP_SUBB: begin
                o_result = diff[7:0];
                o_status_flags[`EXEC_ST_N] = diff[7];
                o_status_flags[`EXEC_ST_OV] = (i_acc[7] != i_src[7]) && (diff[7] != i_acc[7]);
                o_status_flags[`EXEC_ST_Z] = (diff[7:0] == 8'h00);
                o_status_flags[`EXEC_ST_DC] = low_diff[4];
                o_status_flags[`EXEC_ST_C] = diff[8];
                o_flags_valid = 1'b1;
            end
            default: begin
                o_result = 8'h00;
            end
        endcase
    end
endmodule : exec_alu

// ### verilog/exec_core.sv
// executes rotate-right, enter-sleep and subtract-with-borrow over four phases
`include "exec_regs.svh"
module exec_core (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_instr_valid,
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_f_addr,
    input wire logic i_dest_sel,
    input wire logic i_access_sel,
    input wire logic i_ext_en,
    input wire logic [3:0] i_bank_select_reg,
    input wire logic [11:0] i_fsr2,
    input wire logic [7:0] i_reg_rdata,
    input wire logic i_watchdog_wake,
    input wire logic i_other_wake,
    input wire logic i_watchdog_tick,
    output logic o_instr_ready,
    output logic o_busy,
    output logic [11:0] o_reg_addr,
    output logic o_reg_rd,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata,
    output logic [7:0] o_acc,
    output logic [4:0] o_status,
    output logic o_power_down_flag,
    output logic o_expiry_flag,
    output logic [7:0] o_watchdog_counter,
    output logic [7:0] o_watchdog_postscaler,
    output logic o_osc_run,
    output logic o_asleep
);
    typedef struct packed {
        exec_pkg::phase_e phase;
        logic busy;
        logic [1:0] op;
        logic [7:0] f_addr;
        logic dest;
        logic access;
        logic [11:0] addr;
        logic [7:0] src;
        logic [7:0] result;
        logic [4:0] st_flags;
        logic flags_valid;
        logic rd;
        logic wr;
        logic [7:0] wdata;
        logic [7:0] acc;
        logic [4:0] status;
        logic power_down;
        logic expiry;
        logic [7:0] wdt;
        logic [7:0] wdt_ps;
        exec_pkg::run_e run;
        logic ready;
        logic osc_run;
        logic wake_s1;
        logic wake_s2;
        logic oth_s1;
        logic oth_s2;
    } state_s;

    state_s q, d;
    logic [11:0] alu_addr;
    logic [7:0] alu_result;
    logic [4:0] alu_flags;
    logic alu_flags_valid;

    exec_alu u_alu (
        .i_op(q.op),
        .i_f_addr(q.f_addr),
        .i_access_sel(q.access),
        .i_ext_en(i_ext_en),
        .i_bank_sel(i_bank_select_reg),
        .i_fsr2(i_fsr2),
        .i_src(q.src),
        .i_acc(q.acc),
        .i_carry(q.status[`EXEC_ST_C]),
        .o_addr(alu_addr),
        .o_result(alu_result),
        .o_status_flags(alu_flags),
        .o_flags_valid(alu_flags_valid)
    );

    always_comb begin
        d = q;
        d.rd = 1'b0;
        d.wr = 1'b0;
        // wake inputs come from outside, so two stages first
        d.wake_s1 = i_watchdog_wake;
        d.wake_s2 = q.wake_s1;
        d.oth_s1 = i_other_wake;
        d.oth_s2 = q.oth_s1;
        if (q.run == exec_pkg::RUN_ASLEEP) begin
            if (q.wake_s2) begin
                d.expiry = 1'b0;
                d.run = exec_pkg::RUN_ACTIVE;
            end else if (q.oth_s2) begin
                d.run = exec_pkg::RUN_ACTIVE;
            end
        end else begin
            if (i_watchdog_tick) begin
                d.wdt_ps = q.wdt_ps + 8'h01;
                if (q.wdt_ps == 8'hFF) begin
                    d.wdt = q.wdt + 8'h01;
                end
            end
            unique case (q.phase)
                exec_pkg::PH_Q1: begin
                    if (i_instr_valid) begin
                        d.busy = 1'b1;
                        d.op = i_op;
                        d.f_addr = i_f_addr;
                        d.dest = i_dest_sel;
                        d.access = i_access_sel;
                        d.phase = exec_pkg::PH_Q2;
                    end
                end
                exec_pkg::PH_Q2: begin
                    d.addr = alu_addr;
                    d.rd = (q.op != `EXEC_OP_SLEEP);
                    d.phase = exec_pkg::PH_Q3;
                end
                exec_pkg::PH_Q3: begin
                    // read data is taken in the same cycle that the registered read strobe is high
                    d.src = i_reg_rdata;
                    d.phase = exec_pkg::PH_Q4;
                end
                exec_pkg::PH_Q4: begin
                    d.busy = 1'b0;
                    d.phase = exec_pkg::PH_Q1;
                    unique case (q.op)
                        `EXEC_OP_SLEEP: begin
                            d.power_down = 1'b0;
                            d.expiry = 1'b1;
                            d.wdt = `EXEC_WDT_RESET;
                            d.wdt_ps = `EXEC_PS_RESET;
                            d.run = exec_pkg::RUN_ASLEEP;
                        end
                        `EXEC_OP_ROTATE, `EXEC_OP_SUBB: begin
                            if (q.dest) begin
                                d.wr = 1'b1;
                                d.wdata = alu_result;
                            end else begin
                                d.acc = alu_result;
                            end
                            d.status[`EXEC_ST_N] = alu_flags[`EXEC_ST_N];
                            d.status[`EXEC_ST_Z] = alu_flags[`EXEC_ST_Z];
                            if (alu_flags_valid) begin
                                d.status = alu_flags;
                            end
                        end
                        default: begin
                            d.busy = 1'b0;
                        end
                    endcase
                end
            endcase
        end
        // registered so the handshake and oscillator outputs leave a flop
        d.ready = (d.phase == exec_pkg::PH_Q1) && (d.run == exec_pkg::RUN_ACTIVE);
        d.osc_run = (d.run == exec_pkg::RUN_ACTIVE);
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q <= '0;
            q.power_down <= 1'b1;
            q.expiry <= 1'b1;
            q.acc <= `EXEC_ACC_RESET;
            q.run <= exec_pkg::RUN_ACTIVE;
            q.phase <= exec_pkg::PH_Q1;
            q.ready <= 1'b1;
            q.osc_run <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign o_instr_ready = q.ready;
    assign o_busy = q.busy;
    assign o_reg_addr = q.addr;
    assign o_reg_rd = q.rd;
    assign o_reg_wr = q.wr;
    assign o_reg_wdata = q.wdata;
    assign o_acc = q.acc;
    assign o_status = q.status;
    assign o_power_down_flag = q.power_down;
    assign o_expiry_flag = q.expiry;
    assign o_watchdog_counter = q.wdt;
    assign o_watchdog_postscaler = q.wdt_ps;
    assign o_osc_run = q.osc_run;
    assign o_asleep = q.run;
endmodule : exec_core

// ### verification/exec_core_checker.sv
// port assertions for the executer
module exec_core_checker (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_instr_valid,
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_f_addr,
    input wire logic i_dest_sel,
    input wire logic i_access_sel,
    input wire logic [3:0] i_bank_select_reg,
    input wire logic i_watchdog_wake,
    input wire logic o_instr_ready,
    input wire logic [11:0] o_reg_addr,
    input wire logic o_reg_wr,
    input wire logic o_power_down_flag,
    input wire logic o_expiry_flag,
    input wire logic [7:0] o_watchdog_counter,
    input wire logic [7:0] o_watchdog_postscaler,
    input wire logic o_osc_run,
    input wire logic o_asleep
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    logic tk;
    assign tk = i_instr_valid && o_instr_ready;
    // results land three edges after the take, seen one edge later
    AST_ROT_ACC_NO_WR: assert property (tk && i_op == 2'h1 && !i_dest_sel |-> ##4 !o_reg_wr)
        else $error("rotate to accumulator wrote the register");
    AST_DEST_REG: assert property (tk && i_op[0] && i_dest_sel |-> ##4 o_reg_wr)
        else $error("register destination not written");
    AST_SLEEP_PD: assert property (tk && i_op == 2'h2 |-> ##4 !o_power_down_flag)
        else $error("power-down flag not cleared");
    AST_SLEEP_EXP: assert property (tk && i_op == 2'h2 |-> ##4 o_expiry_flag)
        else $error("expiry flag not set");
    AST_SLEEP_WDT: assert property (tk && i_op == 2'h2 |->
        ##4 (o_watchdog_counter | o_watchdog_postscaler) == 8'h00)
        else $error("watchdog not cleared");
    AST_SLEEP_HALT: assert property (tk && i_op == 2'h2 |-> ##4 o_asleep && !o_osc_run)
        else $error("not halted after sleep");
    AST_WAKE_EXP: assert property (o_asleep && i_watchdog_wake |-> ##[1:5] !o_expiry_flag)
        else $error("watchdog wake left expiry set");
    AST_BANK_ADDR: assert property (tk && i_op[0] && i_access_sel |->
        ##3 o_reg_addr == {$past(i_bank_select_reg, 3), $past(i_f_addr, 3)})
        else $error("bank select address wrong");
    cover property (tk && i_op == 2'h2);
    cover property (o_asleep && i_watchdog_wake);
    cover property (tk && i_op == 2'h3 && !i_dest_sel);
endmodule : exec_core_checker

// ### verification/testbench.sv
// self-checking bench for the executer
`define CHK(a, e) begin logic [31:0] av, ev; av = (a); ev = (e); n_tests++; \
    if (av !== ev) begin err_total++; \
    $display("ERROR t=%0t got %h exp %h", $time, av, ev); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_ref_clk = 0, i_rst_b = 0, i_instr_valid = 0, i_dest_sel = 0, i_access_sel = 0;
    logic i_ext_en = 0, i_watchdog_wake = 0, i_other_wake = 0, i_watchdog_tick = 0;
    logic [1:0] i_op = 0;
    logic [7:0] i_f_addr = 0, i_reg_rdata = 0, o_reg_wdata, o_acc;
    logic [7:0] o_watchdog_counter, o_watchdog_postscaler;
    logic [3:0] i_bank_select_reg = 0;
    logic [11:0] i_fsr2 = 0, o_reg_addr;
    logic [4:0] o_status, st_m = 5'h00;
    logic o_instr_ready, o_busy, o_reg_rd, o_reg_wr, o_power_down_flag, o_expiry_flag;
    logic o_osc_run, o_asleep, rdy_s = 0, pd_m = 1, ex_m = 1, slp_s = 0;
    logic [7:0] acc_m = 8'h00;
    logic [4:0] tk_sr = 0;
    logic [31:0] seed = 32'h4795;
    logic [11:0] q_addr[$];
    logic [26:0] q_res[$];
    logic q_wake[$];
    int err_total = 0, n_tests = 0;
    exec_core uut (.*);
    initial forever #50 i_ref_clk = ~i_ref_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic conclude();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic run();
        logic [31:0] r;
        logic [7:0] src, res;
        logic [8:0] s9;
        logic dc;
        r = xs();
        src = r[15:8];
        {i_op, i_f_addr, i_reg_rdata} <= {r[23] ? 2'h3 : 2'h1, r[7:0], src};
        {i_bank_select_reg, i_access_sel, i_ext_en, i_dest_sel} <= r[22:16];
        i_fsr2 <= r[31:20];
        i_instr_valid <= 1'b1;
        do @(posedge i_ref_clk); while (!rdy_s);
        if (!r[18] && r[17] && r[7:0] <= 8'h5F) q_addr.push_back(r[31:20] + {4'h0, r[7:0]});
        else if (r[18]) q_addr.push_back({r[22:19], r[7:0]});
        else q_addr.push_back({r[7:0] >= 8'h60 ? 4'hF : 4'h0, r[7:0]});
        if (!r[23]) begin
            res = {src[0], src[7:1]};
            st_m[4] = res[7];
            st_m[2] = (res == 8'h00);
        end else begin
            s9 = {1'b0, acc_m} + {1'b0, ~src} + {8'h00, st_m[0]};
            dc = ({1'b0, acc_m[3:0]} + {1'b0, ~src[3:0]} + {4'h0, st_m[0]}) > 5'h0F;
            res = s9[7:0];
            st_m = {res[7], acc_m[7] != src[7] && res[7] != acc_m[7], res == 8'h00, dc, s9[8]};
        end
        if (!r[16]) acc_m = res;
        q_res.push_back({r[16], r[16] ? res : 8'h00, acc_m, st_m, pd_m, ex_m, 3'b110});
        repeat (3) @(posedge i_ref_clk);
    endtask : run
    task automatic nap(input logic wd);
        i_op <= 2'h2;
        i_instr_valid <= 1'b1;
        do @(posedge i_ref_clk); while (!rdy_s);
        q_res.push_back({9'h000, acc_m, st_m, 5'b01101});
        pd_m = 1'b0;
        i_instr_valid <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
        ex_m = !wd;
        q_wake.push_back(ex_m);
        i_watchdog_wake <= wd;
        i_other_wake <= !wd;
        wait (!o_asleep);
        @(posedge i_ref_clk);
        i_watchdog_wake <= 1'b0;
        i_other_wake <= 1'b0;
    endtask : nap
    always @(posedge i_ref_clk) begin
        i_watchdog_tick <= ~i_watchdog_tick;
        tk_sr <= {tk_sr[3:0], rdy_s && i_instr_valid};
    end
    always @(negedge i_ref_clk) begin
        rdy_s = o_instr_ready;
        if (o_reg_rd) `CHK(o_reg_addr, q_addr.pop_front())
        if (tk_sr[0]) `CHK(o_busy, 1'b1)
        if (tk_sr[3]) `CHK({o_reg_wr, o_reg_wdata & {8{o_reg_wr}}, o_acc, o_status,
            o_power_down_flag, o_expiry_flag, o_asleep ?
            (o_watchdog_counter | o_watchdog_postscaler) == 8'h00 : 1'b1,
            o_osc_run, o_asleep}, q_res.pop_front())
        // wake seen half a cycle after the edge, clear of the update race
        if (slp_s && !o_asleep) `CHK(o_expiry_flag, q_wake.pop_front())
        slp_s = o_asleep;
    end
    initial begin
        #500000;
        err_total++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            if (i == 25 || i == 45) nap(i == 25);
            run();
        end
        // a held valid would start one more instruction with no note queued
        i_instr_valid <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
        `CHK(q_addr.size() + q_res.size() + q_wake.size(), 0)
        conclude();
    end
endmodule : testbench
bind exec_core exec_core_checker chk (.*);
